// ### verification/rmc_core_checker.sv
/*
 rmc_core_checker: concurrent checks on the ports of rmc_core.
 assumes: apb master holds each request until pready; one pclk domain.
*/
`timescale 1ns/100ps
module rmc_core_checker
    import rmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire rmc_apb_req_type apb_req,
    input wire rmc_apb_rsp_type apb_rsp,
    input wire logic watchdog_clock,
    input wire logic user_reset_n,
    input wire logic timer_external_input,
    input wire logic [11:0] prgdata,
    input wire logic [11:0] prgaddr,
    input wire logic [7:0] ramdati,
    input wire rmc_ram_out_type ram_out,
    input wire logic sleep,
    input wire logic [2:0][7:0] port_in,
    input wire logic [2:0][7:0] port_out,
    input wire logic [2:0][7:0] port_dir
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // write in its access phase, before the answer
    wire logic wr_take = apb_req.psel && apb_req.penable && apb_req.pwrite && !apb_rsp.pready;
    we_pulse_a: assert property (ram_out.we |=> !ram_out.we)
        else $error("ram write strobe longer than one cycle");
    oe_pulse_a: assert property (ram_out.oe |=> !ram_out.oe)
        else $error("ram read strobe longer than one cycle");
    strobe_excl_a: assert property (!(ram_out.we && ram_out.oe))
        else $error("ram read and write strobes together");
    indirect_we_a: assert property (ram_out.we |-> ram_out.addr[4:0] != 5'h00)
        else $error("ram written at the indirect location");
    port_write_a: assert property (wr_take && apb_req.paddr == OFS_PORT_REG_BASE
        |=> port_out[0] == apb_req.pwdata[7:0]) else $error("port latch not written");
    dir_write_a: assert property (wr_take && apb_req.paddr == OFS_DIRECTION_REG_BASE
        |=> port_dir[0] == apb_req.pwdata[7:0]) else $error("direction not written");
    call_jump_a: assert property (wr_take && apb_req.paddr == OFS_COMMAND && !sleep
        && apb_req.pwdata[2:0] == CMD_CALL |=> prgaddr == apb_req.pwdata[19:8])
        else $error("call did not load the target");
    user_reset_a: assert property (!user_reset_n [*4] |-> !sleep
        && prgaddr == RESET_VECTOR && port_out == '0) else $error("user reset not applied");
    cover property (wr_take && apb_req.paddr == OFS_COMMAND);
    cover property ($fell(sleep));
    cover property (ram_out.oe);
endmodule : rmc_core_checker

bind rmc_core rmc_core_checker chk_i (.pclk, .presetn, .apb_req, .apb_rsp, .watchdog_clock,
    .user_reset_n, .timer_external_input, .prgdata, .prgaddr, .ramdati, .ram_out, .sleep,
    .port_in, .port_out, .port_dir);

// ### verification/rmc_mem_model.sv
/*
 rmc_mem_model: asynchronous data ram and program rom beside the core.
 assumes: ram strobes are one-cycle pulses in the pclk domain.
*/
`timescale 1ns/100ps
module rmc_mem_model
    import rmc_pkg::*;
(
    input wire logic pclk,
    input wire rmc_ram_out_type ram_out,
    input wire logic [11:0] prgaddr,
    output logic [7:0] ramdati,
    output logic [11:0] prgdata
);
    logic [7:0] mem [0:255];
    // outside a read the bus shows the inverse, never a stale copy
    assign ramdati = ram_out.oe ? mem[ram_out.addr] : ~mem[ram_out.addr];
    assign prgdata = ~prgaddr;
    always_ff @(posedge pclk) begin
        if (ram_out.we) begin
            mem[ram_out.addr] <= ram_out.wdata;
        end
    end
endmodule : rmc_mem_model

// ### verification/tb.sv
/*
 tb: apb-driven tests of stack, ram addressing, timer, watchdog, sleep, ports.
 assumes: rmc_core with the package build options and an async ram model.
*/
`timescale 1ns/100ps
module tb
    import rmc_pkg::*;
;
    logic pclk = 0;
    logic presetn = 0;
    logic watchdog_clock = 0;
    logic user_reset_n = 1;
    logic timer_external_input = 0;
    logic [2:0][7:0] port_in = '0;
    rmc_apb_req_type apb_req = '0;
    rmc_apb_rsp_type apb_rsp;
    rmc_ram_out_type ram_out;
    logic [11:0] prgdata, prgaddr;
    logic [7:0] ramdati;
    logic sleep;
    logic [2:0][7:0] port_out, port_dir;
    logic [31:0] rdat, t1;
    logic rerr;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int t0;
    logic [11:0] pops [3] = '{12'h301, 12'h201, 12'h301};
    logic [7:0] opt [5] = '{8'h08, 8'h00, 8'h01, 8'h28, 8'h38};
    int per [5] = '{4, 8, 16, 3, 1};
    rmc_core DUT (.pclk, .presetn, .apb_req, .apb_rsp, .watchdog_clock, .user_reset_n,
        .timer_external_input, .prgdata, .prgaddr, .ramdati, .ram_out, .sleep, .port_in,
        .port_out, .port_dir);
    rmc_mem_model mem_i (.pclk, .ram_out, .prgaddr, .ramdati, .prgdata);
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rdat = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task automatic wdog(input int n);
        repeat (n) begin
            @(posedge pclk) watchdog_clock <= 1'b1;
            repeat (4) @(posedge pclk);
            watchdog_clock <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask : wdog
    task automatic give_verdict;
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #200us;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("dir reset", 32'h00ffffff, 32'(port_dir));
        apb(1'b0, OFS_OPTION, '0);
        chk("option reset", 32'hff, rdat);
        apb(1'b1, OFS_COMMAND, 32'h7ff03);
        apb(1'b1, OFS_COMMAND, 32'h4);
        chk("pc wrap", 32'h0, 32'(prgaddr));
        apb(1'b0, OFS_COMMAND, '0);
        chk("pc read", 32'h00fff000, rdat);
        // three calls into two levels: the oldest entry is lost, pops wrap
        apb(1'b1, OFS_COMMAND, 32'h10003);
        for (int i = 2; i < 5; i++) apb(1'b1, OFS_COMMAND, (i << 16) | 1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_COMMAND, 32'h2);
            chk("return addr", 32'(pops[i]), 32'(prgaddr));
        end
        apb(1'b1, OFS_FILE_SELECT_POINTER, 32'h3f);
        apb(1'b1, OFS_FILE_ADDR, 32'h05);
        apb(1'b1, OFS_FILE_DATA, 32'h5a);
        apb(1'b1, OFS_FILE_SELECT_POINTER, 32'h25);
        apb(1'b1, OFS_FILE_ADDR, 32'h00);
        apb(1'b0, OFS_FILE_DATA, '0);
        chk("indirect read", 32'h5a, rdat);
        apb(1'b1, OFS_FILE_SELECT_POINTER, 32'h40);
        apb(1'b1, OFS_FILE_DATA, 32'h77);
        apb(1'b0, OFS_FILE_DATA, '0);
        chk("self indirect", 32'h0, rdat);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, OFS_OPTION, 32'(opt[i]));
            apb(1'b1, OFS_TIMER, 32'ha5);
            t0 = cyc;
            apb(1'b0, OFS_TIMER, '0);
            t1 = rdat;
            if (i < 3) begin
                while (cyc < t0 + 10 * per[i]) @(posedge pclk);
            end else begin
                chk("timer rw", 32'ha5, t1);
                // three toggles from low leave the input high, so the two edges count differently
                repeat (per[i]) begin
                    timer_external_input <= ~timer_external_input;
                    repeat (6) @(posedge pclk);
                end
            end
            apb(1'b0, OFS_TIMER, '0);
            chk("timer count", i < 3 ? 32'd10 : 32'(5 - i), 32'(8'(rdat - t1)));
        end
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, OFS_PORT_REG_BASE + 8'(4 * p), 32'h3c + p);
            chk("port latch", 32'h3c + p, 32'(port_out[p]));
            port_in[p] <= 8'h96 ^ 8'(p);
            repeat (3) @(posedge pclk);
            apb(1'b0, OFS_PORT_REG_BASE + 8'(4 * p), '0);
            chk("port pins", 32'h96 ^ p, rdat);
            apb(1'b1, OFS_DIRECTION_REG_BASE + 8'(4 * p), 32'h0f ^ p);
            chk("port dir", 32'h0f ^ p, 32'(port_dir[p]));
        end
        apb(1'b0, 8'h40, '0);
        chk("unmapped err", 32'h1, 32'(rerr));
        apb(1'b1, OFS_WDT_CFG, 32'h10001);
        apb(1'b1, OFS_COMMAND, 32'h6);
        apb(1'b1, OFS_COMMAND, 32'h5);
        chk("sleep on", 32'h1, 32'(sleep));
        wdog(3);
        chk("woken", 32'h0, 32'(sleep));
        apb(1'b0, OFS_STATUS, '0);
        chk("wake flag", 32'h1, 32'(rdat[1]));
        apb(1'b1, OFS_STATUS, 32'h3);
        apb(1'b1, OFS_COMMAND, 32'h6);
        apb(1'b1, OFS_COMMAND, 32'h5503);
        wdog(3);
        chk("wdog reset addr", 32'h0, 32'(prgaddr));
        apb(1'b0, OFS_STATUS, '0);
        chk("wdog flag", 32'h1, 32'(rdat[0]));
        apb(1'b1, OFS_COMMAND, 32'h5);
        @(posedge pclk) user_reset_n <= 1'b0;
        repeat (6) @(posedge pclk);
        user_reset_n <= 1'b1;
        chk("user wake", 32'h0, 32'(sleep));
        chk("ports cleared", 32'h0, 32'(port_out));
        give_verdict();
    end
endmodule : tb

// ### verilog/rmc_core.sv
/*
 rmc_core: program counter with circular return stack, data RAM address
 forming, timer/counter with prescaler, watchdog, sleep control and three
 8-bit ports, all driven from an APB register slave.
 assumes: pclk runs continuously (sleep is only signalled on the sleep
 output); ram, program memory and port pins are outside this block.
*/
// Overview of operation
// - a call command saves the return address into the return stack
// - return-with-literal pops the top stack entry into the program counter
// - stack is circular; extra pushes overwrite the oldest entry silently
// - stack and its pointer are invisible to software and memory spaces
// - stack depth is a build constant from one to eight, default two
// - ram size up to 256, default 128, and ram type are build constants
// - direct ram address is pointer bits 7:5 joined with five file bits
// - the indirect register accesses the address held in the pointer
// - indirect access to the indirect register reads 00h, writes nothing
// - timer mode without prescaler counts once every four clocks
// - with prescaler assigned the rate divides by two up to 256
// - counter mode counts external input edges, polarity chosen in option
// - the timer register is readable and writable as eight bits
// - watchdog counts on its own clock, also during sleep
// - watchdog has a 7-bit prescaler and a configurable timeout period
// - watchdog timeout while running resets the core
// - watchdog timeout while sleeping wakes the core to continue
// - user reset also wakes the core from sleep
// - port reads return the synchronised pin levels, not the latch
// - port writes update the output latch driving the port outputs
// - a set direction bit makes the pin an input, driver high impedance
`timescale 1ns/100ps

module rmc_core
    import rmc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire rmc_apb_req_type apb_req,
    output rmc_apb_rsp_type apb_rsp,
    input wire logic watchdog_clock,
    input wire logic user_reset_n,
    input wire logic timer_external_input,
    input wire logic [11:0] prgdata,
    output logic [11:0] prgaddr,
    input wire logic [7:0] ramdati,
    output rmc_ram_out_type ram_out,
    output logic sleep,
    input wire logic [2:0][7:0] port_in,
    output logic [2:0][7:0] port_out,
    output logic [2:0][7:0] port_dir
);

    rmc_state_type s;
    rmc_state_type next_s;

    function automatic logic [11:0] pc_limit(input logic [11:0] value);
        return value & 12'(PROG_SIZE - 1);
    endfunction : pc_limit

    function automatic logic [11:0] pc_next(input logic [11:0] value);
        return pc_limit(12'(value + 12'h001));
    endfunction : pc_next

    // bit 8 tells whether a real ram cell is reached
    function automatic logic [8:0] file_address(input logic [7:0] pointer,
                                                input logic [4:0] file_sel);
        logic [7:0] addr;
        logic hit;
        if (file_sel == INDIRECT_FILE) begin
            addr = pointer;
        end else begin
            addr = {pointer[7:5], file_sel};
        end
        // the indirect register pointing at itself reaches no cell
        hit = (addr[4:0] != INDIRECT_FILE) && (9'(addr) < 9'(RAM_SIZE));
        return {hit, addr};
    endfunction : file_address

    function automatic logic reg_mapped(input logic [7:0] ofs);
        logic known;
        known = (ofs[1:0] == 2'h0) && (ofs < OFS_DIRECTION_REG_BASE + 8'(4 * PORT_COUNT));
        return known;
    endfunction : reg_mapped

    // each port owns a latch word and a direction word, twelve bytes apart
    function automatic logic port_hit(input logic [7:0] ofs, input logic [7:0] base,
                                      input int idx);
        return USE_PORTS[idx] && (ofs == 8'(base + 8'(4 * idx)));
    endfunction : port_hit

    function automatic logic [31:0] byte_word(input logic [7:0] value);
        return {24'h000000, value};
    endfunction : byte_word

    // core-level reset: keeps watchdog setup, flags and the bus handshake
    function automatic rmc_state_type core_reset(input rmc_state_type st);
        rmc_state_type r;
        r = st;
        r.program_counter = RESET_VECTOR;
        r.stack = '0;
        r.sp = 3'h0;
        r.file_select_pointer = 8'h00;
        r.option = OPTION_RESET;
        r.timer = 8'h00;
        r.prescale = 8'h00;
        r.base_div = 2'h0;
        r.watchdog_counter = 8'h00;
        r.wdt_pre = 7'h00;
        r.sleep = 1'b0;
        r.port_out = '0;
        r.port_dir = {PORT_COUNT{DIR_RESET}};
        return r;
    endfunction : core_reset

    always_comb begin
        logic access;
        logic wtick;
        logic wdt_timeout;
        logic t0_edge;
        logic src_tick;
        logic [7:0] mask;
        logic [8:0] fa;
        logic [2:0] sp_up;
        logic [2:0] sp_down;
        logic [31:0] rdata;
        rmc_cmd_type op;
        access = 1'b0;
        wtick = 1'b0;
        wdt_timeout = 1'b0;
        t0_edge = 1'b0;
        src_tick = 1'b0;
        mask = 8'h00;
        fa = file_address(s.file_select_pointer, s.file_addr);
        sp_up = (s.sp == 3'(STACK_LEVELS - 1)) ? 3'h0 : 3'(s.sp + 3'h1);
        sp_down = (s.sp == 3'h0) ? 3'(STACK_LEVELS - 1) : 3'(s.sp - 3'h1);
        rdata = 32'h0000_0000;
        op = rmc_cmd_type'(apb_req.pwdata[CMD_OP_LSB +: 3]);

        next_s = s;
        next_s.rsp.pready = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        next_s.ram.we = 1'b0;
        next_s.ram.oe = 1'b0;

        // synchronisers; only the second stage onward is looked at
        next_s.t0_sync = {s.t0_sync[1:0], timer_external_input};
        next_s.wclk_sync = {s.wclk_sync[1:0], watchdog_clock};
        next_s.mclr_sync = {s.mclr_sync[0], user_reset_n};
        next_s.pin_s1 = port_in;
        next_s.pin_s2 = s.pin_s1;

        // watchdog: edges of its own clock, counted whether asleep or not
        // limitation: the watchdog clock must run well below pclk or edges are lost
        wtick = s.wclk_sync[1] & ~s.wclk_sync[2];
        if (USE_WDT && s.wdt_cfg[WDT_EN_BIT] && wtick) begin
            if (s.wdt_pre == s.wdt_cfg[WDT_PRE_LSB +: 7]) begin
                next_s.wdt_pre = 7'h00;
                if (s.watchdog_counter == s.wdt_cfg[WDT_PERIOD_LSB +: 8]) begin
                    wdt_timeout = 1'b1;
                end else begin
                    next_s.watchdog_counter = 8'(s.watchdog_counter + 8'h01);
                end
            end else begin
                next_s.wdt_pre = 7'(s.wdt_pre + 7'h01);
            end
        end

        // timer is frozen in sleep, as the core clock would be stopped
        if (USE_TIMER && !s.sleep) begin
            next_s.base_div = 2'(s.base_div + 2'h1);
            if (s.option[OPT_EDGE_BIT]) begin
                t0_edge = ~s.t0_sync[1] & s.t0_sync[2];
            end else begin
                t0_edge = s.t0_sync[1] & ~s.t0_sync[2];
            end
            if (s.option[OPT_SOURCE_BIT]) begin
                src_tick = t0_edge;
            end else begin
                src_tick = (s.base_div == 2'(TIMER_BASE_CYCLES - 1));
            end
            mask = 8'((9'h002 << s.option[OPT_RATE_LSB +: 3]) - 9'h001);
            if (src_tick) begin
                if (s.option[OPT_PRESCALE_OFF_BIT]) begin
                    next_s.timer = 8'(s.timer + 8'h01);
                end else begin
                    next_s.prescale = 8'(s.prescale + 8'h01);
                    if ((s.prescale & mask) == mask) begin
                        next_s.timer = 8'(s.timer + 8'h01);
                    end
                end
            end
        end

        // pready gates the access so a request still held is not taken twice
        access = apb_req.psel & apb_req.penable & ~s.rsp.pready;

        if (access && s.phase == 2'h0) begin
            next_s.phase = 2'h1;
            if (apb_req.pwrite) begin
                unique case (apb_req.paddr)
                    OFS_COMMAND: begin
                        if (!s.sleep) begin
                            unique case (op)
                                CMD_CALL: begin
                                    next_s.stack[s.sp] = pc_next(s.program_counter);
                                    next_s.sp = sp_up;
                                    next_s.program_counter = pc_limit(apb_req.pwdata[CMD_TARGET_LSB +: 12]);
                                end
                                CMD_RETURN_WITH_LITERAL: begin
                                    next_s.program_counter = s.stack[sp_down];
                                    next_s.sp = sp_down;
                                    next_s.literal = apb_req.pwdata[CMD_LITERAL_LSB +: 8];
                                end
                                CMD_JUMP: begin
                                    next_s.program_counter = pc_limit(apb_req.pwdata[CMD_TARGET_LSB +: 12]);
                                end
                                CMD_STEP: begin
                                    next_s.program_counter = pc_next(s.program_counter);
                                end
                                CMD_SLEEP: begin
                                    if (USE_SLEEP) begin
                                        next_s.sleep = 1'b1;
                                        next_s.watchdog_counter = 8'h00;
                                        next_s.wdt_pre = 7'h00;
                                    end
                                end
                                CMD_CLEAR_WDT: begin
                                    next_s.watchdog_counter = 8'h00;
                                    next_s.wdt_pre = 7'h00;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                    OFS_FILE_SELECT_POINTER: begin
                        next_s.file_select_pointer = apb_req.pwdata[7:0];
                    end
                    OFS_FILE_ADDR: begin
                        next_s.file_addr = apb_req.pwdata[4:0];
                    end
                    OFS_FILE_DATA: begin
                        if (fa[8]) begin
                            next_s.ram.we = 1'b1;
                            next_s.ram.addr = fa[7:0];
                            next_s.ram.wdata = apb_req.pwdata[7:0];
                        end
                    end
                    OFS_OPTION: begin
                        next_s.option = apb_req.pwdata[7:0];
                    end
                    OFS_TIMER: begin
                        // writing the count restarts the prescaler too
                        next_s.timer = apb_req.pwdata[7:0];
                        next_s.prescale = 8'h00;
                    end
                    OFS_WDT_CFG: begin
                        next_s.wdt_cfg = apb_req.pwdata[16:0];
                    end
                    OFS_STATUS: begin
                        if (apb_req.pwdata[ST_WDT_RESET_BIT]) begin
                            next_s.wdt_flag = 1'b0;
                        end
                        if (apb_req.pwdata[ST_WAKE_BIT]) begin
                            next_s.wake_flag = 1'b0;
                        end
                    end
                    default: begin
                        for (int i = 0; i < PORT_COUNT; i++) begin
                            if (port_hit(apb_req.paddr, OFS_PORT_REG_BASE, i)) begin
                                next_s.port_out[i] = apb_req.pwdata[7:0];
                            end
                            if (port_hit(apb_req.paddr, OFS_DIRECTION_REG_BASE, i)) begin
                                next_s.port_dir[i] = apb_req.pwdata[7:0];
                            end
                        end
                    end
                endcase
            end else if (apb_req.paddr == OFS_FILE_DATA && fa[8]) begin
                next_s.ram.oe = 1'b1;
                next_s.ram.addr = fa[7:0];
                next_s.rd_ram = 1'b1;
            end
        end else if (access) begin
            // sync ram data arrives one cycle after the strobe
            if (!s.rd_ram || s.phase == RAM_READ_PHASE) begin
                unique case (apb_req.paddr)
                    OFS_COMMAND: begin
                        rdata = {8'h00, prgdata, s.program_counter};
                    end
                    OFS_FILE_SELECT_POINTER: begin
                        rdata = byte_word(s.file_select_pointer);
                    end
                    OFS_FILE_ADDR: begin
                        rdata = {27'h0000000, s.file_addr};
                    end
                    OFS_FILE_DATA: begin
                        rdata = s.rd_ram ? byte_word(ramdati) : 32'h0000_0000;
                    end
                    OFS_OPTION: begin
                        rdata = byte_word(s.option);
                    end
                    OFS_TIMER: begin
                        rdata = byte_word(s.timer);
                    end
                    OFS_WDT_CFG: begin
                        rdata = {15'h0000, s.wdt_cfg};
                    end
                    OFS_STATUS: begin
                        // the stack pointer is deliberately not shown here
                        rdata = {16'h0000, s.literal, 5'h00, s.sleep, s.wake_flag, s.wdt_flag};
                    end
                    default: begin
                        for (int i = 0; i < PORT_COUNT; i++) begin
                            if (port_hit(apb_req.paddr, OFS_PORT_REG_BASE, i)) begin
                                rdata = byte_word(s.pin_s2[i]);
                            end
                            if (port_hit(apb_req.paddr, OFS_DIRECTION_REG_BASE, i)) begin
                                rdata = byte_word(s.port_dir[i]);
                            end
                        end
                    end
                endcase
                next_s.rsp.prdata = rdata;
                next_s.rsp.pready = 1'b1;
                next_s.rsp.pslverr = ~reg_mapped(apb_req.paddr);
                next_s.phase = 2'h0;
                next_s.rd_ram = 1'b0;
            end else begin
                next_s.phase = 2'(s.phase + 2'h1);
            end
        end

        // resets and wake-up come last so they win over any write to the fields they set
        if (!s.mclr_sync[1]) begin
            next_s = core_reset(next_s);
        end else if (wdt_timeout) begin
            if (s.sleep) begin
                next_s.sleep = 1'b0;
                next_s.watchdog_counter = 8'h00;
                next_s.wdt_pre = 7'h00;
                next_s.wake_flag = 1'b1;
            end else begin
                next_s = core_reset(next_s);
                next_s.wdt_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.program_counter <= RESET_VECTOR;
            s.option <= OPTION_RESET;
            s.port_dir <= {PORT_COUNT{DIR_RESET}};
            s.wdt_cfg <= WDT_CFG_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp = s.rsp;
    assign prgaddr = s.program_counter;
    assign ram_out = s.ram;
    assign sleep = s.sleep;
    assign port_out = s.port_out;
    assign port_dir = s.port_dir;

endmodule : rmc_core

// ### verilog/rmc_pkg.sv
/*
 rmc_pkg: constants, build options and carrier types of the small 8-bit
 controller core block.
 assumes: one clock domain (pclk); the watchdog clock and all pins are
 sampled inside that domain.
*/
package rmc_pkg;

    // build-time configuration
    localparam int STACK_LEVELS = 2;
    localparam int RAM_SIZE = 128;
    localparam bit RAM_SYNC = 1'b0;
    localparam int PROG_SIZE = 2048;
    localparam bit USE_SLEEP = 1'b1;
    localparam bit USE_WDT = 1'b1;
    localparam bit USE_TIMER = 1'b1;
    localparam logic [2:0] USE_PORTS = 3'h7;
    localparam int PORT_COUNT = 3;

    // register byte offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_FILE_SELECT_POINTER = 8'h04;
    localparam logic [7:0] OFS_FILE_ADDR = 8'h08;
    localparam logic [7:0] OFS_FILE_DATA = 8'h0c;
    localparam logic [7:0] OFS_OPTION = 8'h10;
    localparam logic [7:0] OFS_TIMER = 8'h14;
    localparam logic [7:0] OFS_WDT_CFG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_PORT_REG_BASE = 8'h20;
    localparam logic [7:0] OFS_DIRECTION_REG_BASE = 8'h2c;

    // field positions
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_TARGET_LSB = 8;
    localparam int CMD_LITERAL_LSB = 20;
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_PRESCALE_OFF_BIT = 3;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_SOURCE_BIT = 5;
    localparam int WDT_PRE_LSB = 0;
    localparam int WDT_PERIOD_LSB = 8;
    localparam int WDT_EN_BIT = 16;
    localparam int ST_WDT_RESET_BIT = 0;
    localparam int ST_WAKE_BIT = 1;
    localparam int ST_SLEEP_BIT = 2;
    localparam int ST_LITERAL_LSB = 8;

    // values after reset, and the indirect file number
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [16:0] WDT_CFG_RESET = 17'h1ffff;
    localparam logic [4:0] INDIRECT_FILE = 5'h00;

    // cycle counts
    localparam int TIMER_BASE_CYCLES = 4;
    localparam logic [1:0] RAM_READ_PHASE = RAM_SYNC ? 2'h2 : 2'h1;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_CALL,
        CMD_RETURN_WITH_LITERAL,
        CMD_JUMP,
        CMD_STEP,
        CMD_SLEEP,
        CMD_CLEAR_WDT
    } rmc_cmd_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rmc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rmc_apb_rsp_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic oe;
    } rmc_ram_out_type;

    typedef struct packed {
        rmc_apb_rsp_type rsp;
        logic [1:0] phase;
        logic rd_ram;
        logic [11:0] program_counter;
        logic [STACK_LEVELS-1:0][11:0] stack;
        logic [2:0] sp;
        logic [7:0] literal;
        logic [7:0] file_select_pointer;
        logic [4:0] file_addr;
        rmc_ram_out_type ram;
        logic [7:0] option;
        logic [7:0] timer;
        logic [7:0] prescale;
        logic [1:0] base_div;
        logic [2:0] t0_sync;
        logic [2:0] wclk_sync;
        logic [1:0] mclr_sync;
        logic [7:0] watchdog_counter;
        logic [6:0] wdt_pre;
        logic [16:0] wdt_cfg;
        logic wdt_flag;
        logic wake_flag;
        logic sleep;
        logic [2:0][7:0] pin_s1;
        logic [2:0][7:0] pin_s2;
        logic [2:0][7:0] port_out;
        logic [2:0][7:0] port_dir;
    } rmc_state_type;

endpackage : rmc_pkg
